// *** logic/iirep_consts.svh ***
// constants and contract summary for the near-side i2c master controller
// Contract
// - every line needs a pull-up, never floats
// - grounded line is zero, released is one
// - data changes only while clock low
// - start falls, stop rises, clock high
// - seven-bit address, then read/write bit
// - slave acks low through ninth high
// - address and data sent msb first
// - master acks every read byte but last
// - end with stop or repeated start
// - master receives after read bit sent
// - supports 100k, 400k and 1M rates
`ifndef IIREP_CONSTS_SVH
`define IIREP_CONSTS_SVH
// ---------------------------------------------
// timing
// ---------------------------------------------
`define IIREP_CLK_NS        10
`define IIREP_STD_KBPS      100
`define IIREP_FAST_KBPS     400
`define IIREP_FASTP_KBPS    1000
// quarter bit in ref_clk cycles, rounded down: 1e6 ns / kbps / 4 / 10 ns
`define IIREP_QTR(k)        (1000000 / (k) / 4 / `IIREP_CLK_NS)
`define IIREP_MODE_STD      2'h0
`define IIREP_MODE_FAST     2'h1
`define IIREP_MODE_FASTP    2'h2
`define IIREP_ADDR_BITS     7
`define IIREP_BYTE_BITS     8
`define IIREP_ACK_BIT       4'h8
`define IIREP_RW_READ       1'b1
`endif

// *** logic/iirep_master.sv ***
// near-side i2c master that drives the repeater's near lines
`timescale 1ns/1ns
`default_nettype none
`include "iirep_consts.svh"
module iirep_master #(
   parameter int QTR_MIN = 2
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [1:0]        speed_mode,
   input  wire logic              cmd_valid,
   output logic                   cmd_ready,
   input  wire iirep_pkg::iirep_cmd_t cmd,
   output var iirep_pkg::iirep_rsp_t rsp,
   output logic                   busy,
   input  wire logic              near_side_clock_line_i,
   output logic                   near_side_clock_line_o,
   output logic                   near_side_clock_line_oe,
   input  wire logic              near_side_data_line_i,
   output logic                   near_side_data_line_o,
   output logic                   near_side_data_line_oe
);
   // refuse a quarter the ten-bit timer cannot hold
   if (QTR_MIN < 1 || QTR_MIN > 1023) begin : g_qtr_chk
      $error("quarter period must fit the ten-bit timer");
   end

   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_ADDR, ST_ADDR_ACK, ST_WBYTE, ST_WACK,
      ST_RBYTE, ST_RACK, ST_HOLD, ST_STOP, ST_RSTART
   } iirep_state_t;

   // ---------------------------------------------
   // functions
   // ---------------------------------------------
   // quarter bit length for a rate selection
   function automatic logic [9:0] qtr_of(input logic [1:0] m);
      logic [9:0] q;
      q = 10'(`IIREP_QTR(`IIREP_STD_KBPS));
      if (m == `IIREP_MODE_FAST)
         q = 10'(`IIREP_QTR(`IIREP_FAST_KBPS));
      else if (m == `IIREP_MODE_FASTP)
         q = 10'(`IIREP_QTR(`IIREP_FASTP_KBPS));
      return q;
   endfunction

   // ---------------------------------------------
   // line sampling
   // ---------------------------------------------
   logic [1:0] lines_s;
   logic       scl_s;
   logic       sda_s;
   iirep_pin_sync #(.WIDTH(2)) u_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .async_in ({near_side_clock_line_i, near_side_data_line_i}),
      .sync_out (lines_s)
   );
   assign scl_s = lines_s[1];
   assign sda_s = lines_s[0];

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   iirep_state_t     state_ff;
   logic [9:0]       tick_ff;
   logic [1:0]       phase_ff;
   logic [3:0]       bit_ff;
   logic [7:0]       shift_ff;
   logic             scl_low_ff;
   logic             sda_low_ff;
   iirep_pkg::iirep_cmd_t cmd_ff;
   iirep_pkg::iirep_rsp_t rsp_ff;
   logic             qtr_end;
   logic             stretch;

   // released clock still read low: slave stretch or repeater hold,
   // so the high quarter only starts counting once the line is up
   assign stretch = !scl_low_ff && !scl_s && phase_ff == 2'h2;
   assign qtr_end = (tick_ff == 10'h000) && !stretch;
   assign cmd_ready = (state_ff == ST_IDLE) || (state_ff == ST_HOLD);
   assign busy = state_ff != ST_IDLE;

   // quarter-bit timer, reloaded from the selected rate
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         tick_ff <= 10'h000;
      else if (state_ff == ST_IDLE || state_ff == ST_HOLD || qtr_end)
         tick_ff <= (qtr_of(speed_mode) > 10'(QTR_MIN)) ?
                    qtr_of(speed_mode) - 10'h001 : 10'(QTR_MIN - 1);
      else if (!stretch)
         tick_ff <= tick_ff - 10'h001;
   end

   // bit engine: phase 0 clock low set data, 1 raise, 2/3 clock high
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff   <= ST_IDLE;
         phase_ff   <= 2'h0;
         bit_ff     <= 4'h0;
         shift_ff   <= 8'h00;
         scl_low_ff <= 1'b0;
         sda_low_ff <= 1'b0;
         cmd_ff     <= '0;
      end else begin
         case (state_ff)
            ST_IDLE, ST_HOLD: begin
               if (cmd_valid) begin
                  cmd_ff   <= cmd;
                  phase_ff <= 2'h0;
                  bit_ff   <= 4'h0;
                  if (state_ff == ST_IDLE) begin
                     state_ff <= ST_START;
                  end else if (cmd.rstart) begin
                     state_ff <= ST_RSTART;
                  end else begin
                     shift_ff <= cmd.wdata;
                     state_ff <= cmd_ff.rd ? ST_RBYTE : ST_WBYTE;
                  end
               end
            end
            default: begin
               if (qtr_end) begin
                  phase_ff <= phase_ff + 2'h1;
                  case (phase_ff)
                     2'h0: begin
                        // data moves with the clock held low, except the start fall under the still-released idle clock
                        if (state_ff == ST_START)
                           sda_low_ff <= 1'b1;
                        else if (state_ff == ST_STOP)
                           sda_low_ff <= 1'b1;
                        else if (state_ff == ST_RSTART)
                           sda_low_ff <= 1'b0;
                        else if (state_ff == ST_ADDR_ACK ||
                                 state_ff == ST_WACK ||
                                 state_ff == ST_RBYTE)
                           sda_low_ff <= 1'b0;
                        else if (state_ff == ST_RACK)
                           sda_low_ff <= !cmd_ff.last;
                        else
                           sda_low_ff <= !shift_ff[7];
                     end
                     2'h1: begin
                        if (state_ff != ST_START)
                           scl_low_ff <= 1'b0;
                     end
                     2'h2: begin
                        if (state_ff == ST_STOP)
                           sda_low_ff <= 1'b0;
                        else if (state_ff == ST_RSTART)
                           sda_low_ff <= 1'b1;
                        else if (state_ff == ST_RBYTE)
                           shift_ff <= {shift_ff[6:0], sda_s};
                        else if (state_ff == ST_ADDR_ACK ||
                                 state_ff == ST_WACK)
                           shift_ff[0] <= sda_s;
                     end
                     default: begin
                        if (state_ff != ST_STOP)
                           scl_low_ff <= 1'b1;
                        case (state_ff)
                           ST_START, ST_RSTART: begin
                              shift_ff <= {cmd_ff.addr, cmd_ff.rd};
                              bit_ff   <= 4'h0;
                              state_ff <= ST_ADDR;
                           end
                           ST_ADDR, ST_WBYTE: begin
                              shift_ff <= {shift_ff[6:0], 1'b0};
                              bit_ff   <= bit_ff + 4'h1;
                              if (bit_ff == 4'(`IIREP_BYTE_BITS - 1))
                                 state_ff <= (state_ff == ST_ADDR) ?
                                             ST_ADDR_ACK : ST_WACK;
                           end
                           ST_ADDR_ACK: begin
                              if (shift_ff[0])
                                 state_ff <= ST_STOP;
                              else if (cmd_ff.rd == `IIREP_RW_READ) begin
                                 bit_ff   <= 4'h0;
                                 state_ff <= ST_RBYTE;
                              end else begin
                                 bit_ff   <= 4'h0;
                                 shift_ff <= cmd_ff.wdata;
                                 state_ff <= ST_WBYTE;
                              end
                           end
                           ST_RBYTE: begin
                              bit_ff <= bit_ff + 4'h1;
                              if (bit_ff == 4'(`IIREP_BYTE_BITS - 1))
                                 state_ff <= ST_RACK;
                           end
                           ST_WACK, ST_RACK: begin
                              bit_ff <= 4'h0;
                              if (cmd_ff.last || (state_ff == ST_WACK &&
                                                  shift_ff[0]))
                                 state_ff <= ST_STOP;
                              else
                                 state_ff <= ST_HOLD;
                           end
                           default: begin
                              state_ff <= ST_IDLE;
                           end
                        endcase
                     end
                  endcase
               end
            end
         endcase
      end
   end

   // answer register: one-cycle done per byte or failed address
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff.done <= 1'b0;
         if (qtr_end && phase_ff == 2'h3) begin
            if (state_ff == ST_RACK) begin
               rsp_ff.done  <= 1'b1;
               rsp_ff.rdata <= shift_ff;
               rsp_ff.nack  <= 1'b0;
            end else if (state_ff == ST_WACK ||
                         (state_ff == ST_ADDR_ACK && shift_ff[0])) begin
               rsp_ff.done <= 1'b1;
               rsp_ff.nack <= shift_ff[0];
            end
         end
      end
   end
   assign rsp = rsp_ff;

   // open-drain drive: only ever pull low or release
   assign near_side_clock_line_o  = 1'b0;
   assign near_side_clock_line_oe = scl_low_ff;
   assign near_side_data_line_o   = 1'b0;
   assign near_side_data_line_oe  = sda_low_ff;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   // data may only move under a released clock to frame a transfer
   data_stable_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (!scl_low_ff && $past(!scl_low_ff) && $changed(sda_low_ff))
      |-> (state_ff inside {ST_START, ST_STOP, ST_RSTART}))
      else $error("data moved with clock released");
   stop_edge_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_STOP && $fell(sda_low_ff)) |-> !scl_low_ff)
      else $error("stop edge with clock low");
   start_edge_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_START && $rose(sda_low_ff)) |-> !scl_low_ff)
      else $error("start edge with clock low");
   rstart_edge_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_RSTART && $rose(sda_low_ff)) |-> !scl_low_ff)
      else $error("repeated start edge with clock low");
   ack_release_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_ADDR_ACK && phase_ff == 2'h2) |-> !sda_low_ff)
      else $error("data held during address ack");
   read_ack_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_RACK && phase_ff == 2'h2)
      |-> (sda_low_ff == !cmd_ff.last))
      else $error("wrong read acknowledge");
   read_release_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_RBYTE && phase_ff == 2'h2) |-> !sda_low_ff)
      else $error("master drove data while receiving");
   open_drain_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      !near_side_clock_line_o && !near_side_data_line_o)
      else $error("line driven high");
   idle_release_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_IDLE && $past(state_ff) == ST_IDLE)
      |-> (!scl_low_ff && !sda_low_ff))
      else $error("idle bus not released");
   // bit counters never run past a byte in any shifting state
   byte_count_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_WBYTE) |-> (bit_ff < 4'(`IIREP_BYTE_BITS)))
      else $error("byte ran past eight bits");
   addr_count_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_ADDR) |-> (bit_ff < 4'(`IIREP_BYTE_BITS)))
      else $error("address ran past eight bits");
   rbyte_count_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_RBYTE) |-> (bit_ff < 4'(`IIREP_BYTE_BITS)))
      else $error("read byte ran past eight bits");
   // the bit on the line is the top of the shifter, low for a zero
   addr_bit_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_ADDR && phase_ff == 2'h1)
      |-> (sda_low_ff == !shift_ff[7]))
      else $error("address bit not msb first");
   // waiting between bytes keeps the clock low so nobody sees a frame
   hold_clock_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_HOLD) |-> scl_low_ff)
      else $error("clock released while holding");
   // a stretched quarter must freeze the bit engine
   stretch_hold_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      stretch |=> ($stable(phase_ff) && $stable(state_ff)))
      else $error("engine moved during clock stretch");
   done_pulse_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      rsp_ff.done |=> !rsp_ff.done)
      else $error("done held longer than one cycle");
   stop_idle_a: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      (state_ff == ST_STOP && qtr_end && phase_ff == 2'h3)
      |=> (state_ff == ST_IDLE && !sda_low_ff && !scl_low_ff))
      else $error("stop did not leave the bus released");
endmodule
`default_nettype wire

// *** logic/iirep_pin_sync.sv ***
// two-flop synchroniser for the sampled line levels
`timescale 1ns/1ns
`default_nettype none
module iirep_pin_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // released lines read as one after reset, matching idle pull-ups
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         meta_ff <= '1;
         sync_ff <= '1;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule
`default_nettype wire

// *** logic/iirep_pkg.sv ***
// types shared by the near-side i2c master controller
package iirep_pkg;
   // command from the user side
   typedef struct packed {
      logic [6:0] addr;
      logic       rd;
      logic [7:0] wdata;
      logic       last;
      logic       rstart;
   } iirep_cmd_t;
   // answer to the user side
   typedef struct packed {
      logic [7:0] rdata;
      logic       nack;
      logic       done;
   } iirep_rsp_t;
endpackage

// *** tb/iirep_partner.sv ***
// repeater model with a far-side target behind it
`timescale 1ns/1ns
`default_nettype none
module iirep_partner #(
   parameter int         TX_NS = 90,
   parameter int         RX_NS = 67,
   parameter logic [6:0] ADDR  = 7'h2C,
   parameter logic [7:0] RBASE = 8'h96
) (
   input  wire logic       supply_ok,
   input  wire logic       clk_oe,
   input  wire logic       dat_oe,
   output wire logic       near_clk,
   output wire logic       near_dat,
   output wire logic       far_clk,
   output wire logic       far_dat,
   output logic [7:0]      wbyte,
   output int              n_start,
   output int              n_stop
);
   wire logic  fc_pull, fd_pull, nc_hold, nd_hold;
   logic       spull, act, rd, ph, mack;
   logic [3:0] bitn;
   logic [7:0] sh, tx, nrd;
   // ---------------------------------------------
   // repeater paths
   // ---------------------------------------------
   // only the master's own low goes across, so the hold cannot latch
   assign #(TX_NS) fc_pull = supply_ok & clk_oe;
   assign #(TX_NS) fd_pull = supply_ok & dat_oe;
   assign #(RX_NS) nc_hold = supply_ok & ~far_clk;
   assign #(RX_NS) nd_hold = supply_ok & ~far_dat;
   // pull-ups on every line: released reads one
   assign far_clk  = ~fc_pull;
   assign far_dat  = ~(fd_pull | spull);
   assign near_clk = ~(clk_oe | nc_hold);
   assign near_dat = ~(dat_oe | nd_hold);
   // ---------------------------------------------
   // far-side target
   // ---------------------------------------------
   initial begin
      act = 0; spull = 0; n_start = 0; n_stop = 0; wbyte = 8'h00;
   end
   // data edges while the clock is high frame a transfer
   always @(negedge far_dat) if (far_clk === 1'b1) begin
      // the start's own clock fall rolls the count over to zero
      act = 1; bitn = 4'hF; ph = 0; spull = 0; nrd = 0; n_start++;
   end
   always @(posedge far_dat) if (far_clk === 1'b1) begin
      act = 0; spull = 0; n_stop++;
   end
   // sample on the rising clock
   always @(posedge far_clk) if (act) begin
      if (bitn < 8) sh = {sh[6:0], far_dat};
      else mack = ~far_dat;
   end
   // drive only just after the falling clock
   always @(negedge far_clk) if (act) begin
      if (bitn == 8) begin
         bitn = 0;
         if (rd && (!ph || mack)) begin
            tx = RBASE + nrd; nrd++; spull = ~tx[7];
         end else begin
            spull = 0; act = ~rd;
         end
         ph = 1;
      end else begin
         bitn++;
         if (bitn == 8) begin
            if (!ph) begin
               rd = sh[0]; spull = (sh[7:1] == ADDR); act = spull;
            end else if (!rd) begin
               wbyte = sh; spull = 1;
            end else spull = 0;
         end else if (rd && ph) spull = ~tx[4'h7 - bitn];
      end
   end
endmodule
`default_nettype wire

// *** tb/test_isolated_i2c_line_repeater.sv ***
// bench: near-side master against the repeater and far target
`timescale 1ns/1ns
`default_nettype none
module test_isolated_i2c_line_repeater;
   localparam logic [6:0] ADDR  = 7'h2C;
   localparam logic [7:0] RBASE = 8'h96;
   logic                  ref_clk, rst_n, cmd_valid, cmd_ready, busy;
   logic                  supply_ok, clk_oe, dat_oe;
   logic [1:0]            speed_mode;
   iirep_pkg::iirep_cmd_t cmd;
   iirep_pkg::iirep_rsp_t rsp;
   wire logic             near_clk, near_dat, far_clk, far_dat;
   logic [7:0]            wbyte;
   int                    n_start, n_stop, s0, p0, failures, tests_run;
   iirep_master iirep_master_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .speed_mode(speed_mode), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd(cmd), .rsp(rsp), .busy(busy), .near_side_clock_line_i(near_clk),
      .near_side_clock_line_o(), .near_side_clock_line_oe(clk_oe),
      .near_side_data_line_i(near_dat), .near_side_data_line_o(),
      .near_side_data_line_oe(dat_oe));
   iirep_partner #(.ADDR(ADDR), .RBASE(RBASE)) iirep_partner_i (
      .supply_ok(supply_ok), .clk_oe(clk_oe), .dat_oe(dat_oe),
      .near_clk(near_clk), .near_dat(near_dat), .far_clk(far_clk),
      .far_dat(far_dat), .wbyte(wbyte), .n_start(n_start), .n_stop(n_stop));
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   initial begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
      end
   endtask
   task automatic set_in(input logic [1:0] m, input logic s);
      @(posedge ref_clk);
      speed_mode <= m;
      supply_ok <= s;
      s0 = n_start;
      p0 = n_stop;
   endtask
   // offer one command, hold it until taken, then wait for the answer
   task automatic xact(input logic [6:0] a, input logic r,
                       input logic [7:0] w, input logic l, input logic rs);
      int n;
      n = 0;
      @(posedge ref_clk);
      cmd <= '{addr: a, rd: r, wdata: w, last: l, rstart: rs};
      cmd_valid <= 1'b1;
      #1;
      while (cmd_ready !== 1'b1 && n < 30000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      #1;
      while (rsp.done !== 1'b1 && n < 30000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check(n < 30000, 1'b1);
   endtask
   // extra cycles let the far side see the stop through the delays
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 20000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      repeat (50) @(posedge ref_clk);
      check({busy, far_clk, far_dat}, 3'h3);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_write;
      set_in(2'h1, 1'b1);
      xact(ADDR, 1'b0, 8'hA5, 1'b1, 1'b0);
      check(rsp.nack, 1'b0);
      check(wbyte, 8'hA5);
      wait_idle;
      check(n_start - s0, 32'h1);
      check(n_stop - p0, 32'h1);
   endtask
   task automatic t_read;
      set_in(2'h2, 1'b1);
      xact(ADDR, 1'b1, 8'h00, 1'b0, 1'b0);
      check(rsp.rdata, RBASE);
      xact(ADDR, 1'b1, 8'h00, 1'b1, 1'b0);
      check(rsp.rdata, RBASE + 8'h01);
      wait_idle;
      check(n_stop - p0, 32'h1);
   endtask
   task automatic t_nack;
      set_in(2'h0, 1'b1);
      xact(ADDR ^ 7'h01, 1'b0, 8'h3C, 1'b1, 1'b0);
      check(rsp.nack, 1'b1);
      wait_idle;
   endtask
   task automatic t_rstart;
      set_in(2'h1, 1'b1);
      xact(ADDR, 1'b0, 8'h5A, 1'b0, 1'b0);
      check(rsp.nack, 1'b0);
      check(wbyte, 8'h5A);
      xact(ADDR, 1'b1, 8'h00, 1'b1, 1'b1);
      check(rsp.rdata, RBASE);
      wait_idle;
      check(n_start - s0, 32'h2);
      check(n_stop - p0, 32'h1);
   endtask
   // unpowered repeater leaves far lines released, so nobody answers
   task automatic t_power;
      set_in(2'h2, 1'b0);
      xact(ADDR, 1'b0, 8'hC3, 1'b1, 1'b0);
      check(rsp.nack, 1'b1);
      check(wbyte, 8'h5A);
      check(n_start - s0, 32'h0);
      wait_idle;
      set_in(2'h2, 1'b1);
   endtask
   task automatic final_report;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // watchdog well past the roughly 30000 cycles the tests need
   initial begin
      repeat (80000) @(posedge ref_clk);
      failures++;
      final_report;
   end
   initial begin
      failures = 0;
      tests_run = 0;
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      speed_mode = 2'h1;
      supply_ok = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      check({busy, cmd_ready, clk_oe, dat_oe, rsp.done}, 5'h08);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (30) @(posedge ref_clk);
      check({near_clk, near_dat, far_clk, far_dat}, 4'hF);
      t_write;
      t_read;
      t_nack;
      t_rstart;
      t_power;
      final_report;
   end
endmodule
`default_nettype wire
